/* File: cmps_core_regs.sv */
// core mode, privilege, stack pointer and program status register logic
`timescale 1ns/1ps
module cmps_core_regs (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic vec_valid,
    input wire logic [31:0] vec_data,
    input wire cmps_pkg::cmps_sreg_req_s sreg_req,
    input wire cmps_pkg::cmps_reg_req_s reg_req,
    input wire cmps_pkg::cmps_flag_upd_s flag_upd,
    input wire cmps_pkg::cmps_exec_upd_s exec_upd,
    input wire logic sat_set,
    input wire logic pc_load,
    input wire logic [31:0] pc_target,
    input wire logic push_req,
    input wire logic [31:0] push_data,
    input wire logic pop_req,
    input wire logic exc_entry,
    input wire logic [8:0] exc_num,
    input wire logic exc_return,
    input wire logic svc_req,
    input wire logic cps_req,
    input wire logic cps_set,
    input wire logic cps_all,
    input wire logic periph_req,
    output logic vec_rd,
    output logic [31:0] vec_addr,
    output logic core_ready,
    output logic [31:0] sreg_rdata,
    output logic sreg_ack,
    output logic sreg_denied,
    output logic [31:0] reg_rdata,
    output logic reg_ack,
    output logic mem_wr,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    output logic handler_mode,
    output logic privileged,
    output logic use_psp,
    output logic [31:0] stack_top_pointer,
    output logic [31:0] program_counter,
    output logic [31:0] return_link,
    output logic svc_taken,
    output logic cps_denied,
    output logic periph_denied
);
    import cmps_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    cmps_boot_e boot;
    logic ctrl_npriv, ctrl_spsel;
    logic [31:0] main_stack_pointer, process_stack_pointer;
    logic [4:0] flags;
    logic [8:0] exception_number_field;
    logic exec_t;
    logic [1:0] exec_hi;
    logic [5:0] exec_lo;
    logic cfg_mask, all_mask;
    logic [7:0] base_mask;
    logic [31:0] general_purpose_regs [0:12];

    function automatic logic priv_only(input cmps_sreg_e sel);
        return !(sel == CMPS_SR_FLAGS || sel == CMPS_SR_PSP);
    endfunction

    function automatic logic [31:0] view_mask(input cmps_sreg_e sel);
        logic [31:0] m;
        m = 32'h0000_0000;
        if (sel inside {CMPS_SR_FLAGS, CMPS_SR_FLAGS_EXC, CMPS_SR_FLAGS_EXEC, CMPS_SR_ALL})
            m[CMPS_FLAGS_MSB:CMPS_FLAGS_LSB] = '1;
        if (sel inside {CMPS_SR_FLAGS_EXC, CMPS_SR_ALL, CMPS_SR_EXC, CMPS_SR_EXC_EXEC})
            m[CMPS_EXC_MSB:0] = '1;
        return m;
    endfunction

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire run = (boot == CMPS_RUN);
    wire priv_now = handler_mode | ~ctrl_npriv;
    wire use_psp_now = ~handler_mode & ctrl_spsel;
    // register 13 is the active pointer
    wire [31:0] sp_now = use_psp_now ? process_stack_pointer : main_stack_pointer;
    wire sr_valid = sreg_req.valid & run;
    wire sr_refuse = sr_valid & priv_only(sreg_req.sel) & ~priv_now;
    wire sr_wr = sr_valid & sreg_req.write & ~sr_refuse;
    wire [31:0] sel_mask = view_mask(sreg_req.sel);
    // only the flags field takes writes, through any view that holds it
    wire flags_wr = sr_wr & sel_mask[CMPS_FLAGS_LSB]
                    & (sreg_req.sel != CMPS_SR_EXC_EXEC);
    // three disjoint views in one word
    wire [31:0] psr_full = {flags, exec_hi, exec_t, 8'h00, exec_lo, 1'b0,
                            exception_number_field};
    wire [31:0] psr_read = psr_full & sel_mask;
    wire [31:0] ctrl_word = {30'h0000_0000, ctrl_spsel, ctrl_npriv};
    wire [31:0] sr_value =
        (sreg_req.sel == CMPS_SR_MSP) ? main_stack_pointer :
        (sreg_req.sel == CMPS_SR_PSP) ? process_stack_pointer :
        (sreg_req.sel == CMPS_SR_CFG_MASK) ? {31'h0000_0000, cfg_mask} :
        (sreg_req.sel == CMPS_SR_ALL_MASK) ? {31'h0000_0000, all_mask} :
        (sreg_req.sel == CMPS_SR_BASE_MASK) ? {24'h00_0000, base_mask} :
        (sreg_req.sel == CMPS_SR_CONTROL) ? ctrl_word : psr_read;
    wire [31:0] next_sreg_rdata = sr_refuse ? 32'h0000_0000 : sr_value;

    wire rg_valid = reg_req.valid & run;
    wire rg_wr = rg_valid & reg_req.write;
    wire rg_gpr = reg_req.idx < CMPS_GPR_COUNT;
    wire [31:0] next_reg_rdata =
        rg_gpr ? general_purpose_regs[reg_req.idx] :
        (reg_req.idx == CMPS_REG_SP) ? sp_now :
        (reg_req.idx == CMPS_REG_LINK) ? return_link : program_counter;

    // full descending: decrement before the store
    wire do_push = push_req & run;
    wire do_pop = pop_req & run & ~push_req;
    wire [31:0] sp_adj = do_push ? sp_now - CMPS_STACK_WORD : sp_now + CMPS_STACK_WORD;
    wire sp_adj_en = do_push | do_pop;
    wire sp_reg_wr = rg_wr & (reg_req.idx == CMPS_REG_SP);

    // main pointer from the first vector word
    wire next_msp_sel_vec = (boot == CMPS_LOAD_SP) & vec_valid;
    wire [31:0] next_msp =
        next_msp_sel_vec ? vec_data :
        (sp_adj_en & ~use_psp_now) ? sp_adj :
        (sp_reg_wr & ~use_psp_now) ? reg_req.wdata :
        (sr_wr & sreg_req.sel == CMPS_SR_MSP) ? sreg_req.wdata : main_stack_pointer;
    wire [31:0] next_psp =
        (sp_adj_en & use_psp_now) ? sp_adj :
        (sp_reg_wr & use_psp_now) ? reg_req.wdata :
        (sr_wr & sreg_req.sel == CMPS_SR_PSP) ? sreg_req.wdata : process_stack_pointer;

    // program counter from the second vector word
    wire [31:0] pc_raw =
        ((boot == CMPS_LOAD_PC) & vec_valid) ? vec_data :
        (rg_wr & reg_req.idx == CMPS_REG_PC) ? reg_req.wdata :
        (pc_load & run) ? pc_target : program_counter;
    wire [31:0] next_pc = pc_raw & CMPS_PC_ALIGN_MASK;

    // control only changes from privileged software
    wire ctrl_wr = sr_wr & (sreg_req.sel == CMPS_SR_CONTROL);
    wire next_npriv = ctrl_wr ? sreg_req.wdata[CMPS_CTRL_NPRIV_BIT] : ctrl_npriv;
    wire next_spsel = ctrl_wr ? sreg_req.wdata[CMPS_CTRL_SPSEL_BIT] : ctrl_spsel;

    // entry wins over return in the same cycle
    wire ent = exc_entry & run;
    wire ret = exc_return & run & ~exc_entry;
    wire next_handler = ent ? 1'b1 : (ret ? 1'b0 : handler_mode);
    // number cleared back to thread value on return
    wire [8:0] next_exc = ent ? exc_num : (ret ? CMPS_EXC_THREAD : exception_number_field);

    wire [3:0] next_nzcv = flag_upd.valid ? flag_upd.nzcv :
                           flags_wr ? sreg_req.wdata[CMPS_FLAGS_MSB:CMPS_FLAGS_LSB+1] : flags[4:1];
    // saturation set wins over software clear
    wire next_q = sat_set | (flags_wr ? sreg_req.wdata[CMPS_FLAGS_LSB] : flags[0]);

    // state change and system peripherals need privilege
    wire cps_ok = cps_req & run & priv_now;
    wire next_cfg_mask = (cps_ok & ~cps_all) ? cps_set :
                         (sr_wr & sreg_req.sel == CMPS_SR_CFG_MASK) ? sreg_req.wdata[0] : cfg_mask;
    wire next_all_mask = (cps_ok & cps_all) ? cps_set :
                         (sr_wr & sreg_req.sel == CMPS_SR_ALL_MASK) ? sreg_req.wdata[0] : all_mask;
    wire [7:0] next_base_mask = (sr_wr & sreg_req.sel == CMPS_SR_BASE_MASK) ?
                                sreg_req.wdata[CMPS_BASE_MASK_MSB:0] : base_mask;
    // control bit 1 picks process pointer
    wire next_use_psp = ~next_handler & next_spsel;

    // ----------------------------------------------------------------
    // boot vector fetch
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            boot <= CMPS_LOAD_SP;
        end else if (vec_valid) begin
            unique case (boot)
                CMPS_LOAD_SP: boot <= CMPS_LOAD_PC;
                CMPS_LOAD_PC: boot <= CMPS_RUN;
                CMPS_RUN: boot <= CMPS_RUN;
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            vec_rd <= 1'b1;
            vec_addr <= CMPS_MSP_VECTOR_ADDR;
            core_ready <= 1'b0;
        end else begin
            vec_rd <= ~(vec_valid & boot == CMPS_LOAD_PC) & ~core_ready;
            vec_addr <= next_msp_sel_vec ? CMPS_PC_VECTOR_ADDR : vec_addr;
            core_ready <= core_ready | (vec_valid & boot == CMPS_LOAD_PC);
        end
    end

    // ----------------------------------------------------------------
    // core registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            handler_mode <= 1'b0;
            {ctrl_spsel, ctrl_npriv} <= CMPS_CONTROL_RESET;
            main_stack_pointer <= 32'h0000_0000;
            process_stack_pointer <= 32'h0000_0000;
            program_counter <= 32'h0000_0000;
            return_link <= CMPS_LR_RESET;
            flags <= CMPS_FLAGS_RESET;
            exception_number_field <= CMPS_EXC_THREAD;
            exec_t <= CMPS_PSR_RESET[CMPS_T_BIT];
            exec_hi <= CMPS_PSR_RESET[CMPS_EXEC_HI_MSB:CMPS_EXEC_HI_LSB];
            exec_lo <= CMPS_PSR_RESET[CMPS_EXEC_LO_MSB:CMPS_EXEC_LO_LSB];
            cfg_mask <= 1'b0;
            all_mask <= 1'b0;
            base_mask <= 8'h00;
        end else begin
            handler_mode <= next_handler;
            ctrl_npriv <= next_npriv;
            ctrl_spsel <= next_spsel;
            main_stack_pointer <= next_msp;
            process_stack_pointer <= next_psp;
            program_counter <= next_pc;
            if (rg_wr && reg_req.idx == CMPS_REG_LINK) begin
                return_link <= reg_req.wdata;
            end
            flags <= {next_nzcv, next_q};
            exception_number_field <= next_exc;
            if (exec_upd.valid) begin
                exec_t <= exec_upd.t;
                exec_hi <= exec_upd.hi;
                exec_lo <= exec_upd.lo;
            end
            cfg_mask <= next_cfg_mask;
            all_mask <= next_all_mask;
            base_mask <= next_base_mask;
        end
    end

    always_ff @(posedge clock) begin
        if (rg_wr && rg_gpr) begin
            general_purpose_regs[reg_req.idx] <= reg_req.wdata;
        end
    end

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            privileged <= 1'b1;
            use_psp <= 1'b0;
            stack_top_pointer <= 32'h0000_0000;
            sreg_rdata <= 32'h0000_0000;
            sreg_ack <= 1'b0;
            sreg_denied <= 1'b0;
            reg_rdata <= 32'h0000_0000;
            reg_ack <= 1'b0;
            mem_wr <= 1'b0;
            mem_addr <= 32'h0000_0000;
            mem_wdata <= 32'h0000_0000;
            svc_taken <= 1'b0;
            cps_denied <= 1'b0;
            periph_denied <= 1'b0;
        end else begin
            privileged <= next_handler | ~next_npriv;
            use_psp <= next_use_psp;
            stack_top_pointer <= next_use_psp ? next_psp : next_msp;
            sreg_rdata <= (sr_valid & ~sreg_req.write) ? next_sreg_rdata : 32'h0000_0000;
            sreg_ack <= sr_valid;
            sreg_denied <= sr_refuse;
            reg_rdata <= (rg_valid & ~reg_req.write) ? next_reg_rdata : 32'h0000_0000;
            reg_ack <= rg_valid;
            mem_wr <= do_push;
            mem_addr <= do_push ? sp_adj : mem_addr;
            mem_wdata <= do_push ? push_data : mem_wdata;
            // supervisor call open to every level
            svc_taken <= svc_req & run;
            cps_denied <= cps_req & run & ~priv_now;
            periph_denied <= periph_req & run & ~priv_now;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    sequence s_push;
        push_req && run && !exc_entry && !exc_return && !ctrl_wr;
    endsequence
    sequence s_store(logic [31:0] old_sp);
        mem_wr && mem_addr == old_sp - CMPS_STACK_WORD && stack_top_pointer == mem_addr;
    endsequence

    a_boot_thread: assert property ($rose(core_ready) |-> !handler_mode)
        else $error("core left reset outside application mode");
    a_exc_return: assert property (exc_return && !exc_entry && run
        |=> !handler_mode && exception_number_field == CMPS_EXC_THREAD)
        else $error("exception return did not restore application mode");
    a_handler_priv: assert property (handler_mode |-> privileged && !use_psp)
        else $error("handler mode not privileged on main stack");
    a_ctrl_guard: assert property (sr_valid && sreg_req.write && !priv_now
        && sreg_req.sel == CMPS_SR_CONTROL
        |=> $stable(ctrl_npriv) && $stable(ctrl_spsel) && sreg_denied)
        else $error("unprivileged write changed control");
    a_svc_taken: assert property (svc_req && run |=> svc_taken)
        else $error("supervisor call not taken");
    a_push_order: assert property (s_push |=> s_store($past(sp_now)))
        else $error("push did not pre-decrement the pointer");
    a_sp_select: assert property (!handler_mode |-> use_psp == ctrl_spsel)
        else $error("pointer selection differs from control bit");
    a_msp_vector: assert property (boot == CMPS_LOAD_SP && vec_valid
        |=> main_stack_pointer == $past(vec_data) && vec_addr == CMPS_PC_VECTOR_ADDR)
        else $error("main pointer not loaded from first vector");
    a_pc_align: assert property (program_counter[0] == 1'b0)
        else $error("program counter bit 0 set");
    a_exec_zero: assert property (sr_valid && !sreg_req.write
        && sreg_req.sel == CMPS_SR_EXEC |=> sreg_rdata == 32'h0000_0000)
        else $error("execution state read not zero");
    a_q_sticky: assert property (sat_set |=> flags[0] ##1 (flags[0] || $past(flags_wr)))
        else $error("saturation flag lost");
    a_refuse_zero: assert property (sr_refuse && !sreg_req.write
        |=> sreg_rdata == 32'h0000_0000 && sreg_denied)
        else $error("refused read returned data");

endmodule

/* File: cmps_pkg.sv */
// constants, types and carriers for the core mode, privilege and status registers
package cmps_pkg;

    // ----------------------------------------------------------------
    // addresses and reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] CMPS_MSP_VECTOR_ADDR = 32'h0000_0000;
    localparam logic [31:0] CMPS_PC_VECTOR_ADDR = 32'h0000_0004;
    localparam logic [31:0] CMPS_LR_RESET = 32'h0FFF_FFFF;
    localparam logic [31:0] CMPS_PSR_RESET = 32'h0100_0000;
    localparam logic [4:0] CMPS_FLAGS_RESET = 5'h00;
    localparam logic [1:0] CMPS_CONTROL_RESET = 2'h0;
    localparam logic [8:0] CMPS_EXC_THREAD = 9'h000;
    localparam logic [31:0] CMPS_STACK_WORD = 32'h0000_0004;
    localparam logic [31:0] CMPS_PC_ALIGN_MASK = 32'hFFFF_FFFE;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CMPS_FLAGS_MSB = 31;
    localparam int CMPS_FLAGS_LSB = 27;
    localparam int CMPS_T_BIT = 24;
    localparam int CMPS_EXEC_HI_MSB = 26;
    localparam int CMPS_EXEC_HI_LSB = 25;
    localparam int CMPS_EXEC_LO_MSB = 15;
    localparam int CMPS_EXEC_LO_LSB = 10;
    localparam int CMPS_EXC_MSB = 8;
    localparam int CMPS_CTRL_NPRIV_BIT = 0;
    localparam int CMPS_CTRL_SPSEL_BIT = 1;
    localparam int CMPS_BASE_MASK_MSB = 7;
    localparam logic [3:0] CMPS_GPR_COUNT = 4'hD;
    localparam logic [3:0] CMPS_REG_SP = 4'hD;
    localparam logic [3:0] CMPS_REG_LINK = 4'hE;
    localparam logic [3:0] CMPS_REG_PC = 4'hF;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {CMPS_LOAD_SP, CMPS_LOAD_PC, CMPS_RUN} cmps_boot_e;

    typedef enum logic [3:0] {
        CMPS_SR_FLAGS, CMPS_SR_FLAGS_EXC, CMPS_SR_FLAGS_EXEC, CMPS_SR_ALL,
        CMPS_SR_EXC, CMPS_SR_EXEC, CMPS_SR_EXC_EXEC, CMPS_SR_MSP, CMPS_SR_PSP,
        CMPS_SR_CFG_MASK, CMPS_SR_BASE_MASK, CMPS_SR_ALL_MASK, CMPS_SR_CONTROL
    } cmps_sreg_e;

    typedef struct packed {
        logic valid;
        logic write;
        cmps_sreg_e sel;
        logic [31:0] wdata;
    } cmps_sreg_req_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [3:0] idx;
        logic [31:0] wdata;
    } cmps_reg_req_s;

    typedef struct packed {
        logic valid;
        logic [3:0] nzcv;
    } cmps_flag_upd_s;

    typedef struct packed {
        logic valid;
        logic t;
        logic [1:0] hi;
        logic [5:0] lo;
    } cmps_exec_upd_s;

endpackage

/* File: core_mode_privilege_and_status_regs_tb.sv */
// self-checking testbench for the core mode, privilege and status registers
`timescale 1ns/1ps
module core_mode_privilege_and_status_regs_tb;
    import cmps_pkg::*;
    localparam logic [31:0] SP_VAL = 32'h2000_8000;
    localparam logic [31:0] PC_VAL = 32'h0000_0101;
    localparam logic [31:0] PSP_VAL = 32'h2000_1000;
    logic clock = 0, arst_n = 0, vec_valid = 0, sat_set = 0, pc_load = 0, push_req = 0;
    logic pop_req = 0, exc_entry = 0, exc_return = 0, svc_req = 0, cps_req = 0;
    logic cps_set = 0, cps_all = 0, periph_req = 0;
    logic [31:0] vec_data = 0, pc_target = 0, push_data = 0;
    logic [8:0] exc_num = 0;
    cmps_sreg_req_s sreg_req = '0;
    cmps_reg_req_s reg_req = '0;
    cmps_flag_upd_s flag_upd = '0;
    cmps_exec_upd_s exec_upd = '0;
    logic vec_rd, core_ready, sreg_ack, sreg_denied, reg_ack, mem_wr, handler_mode;
    logic privileged, use_psp, svc_taken, cps_denied, periph_denied;
    logic [31:0] vec_addr, sreg_rdata, reg_rdata, mem_addr, mem_wdata;
    logic [31:0] stack_top_pointer, program_counter, return_link;
    int bad_count = 0, compares = 0, cycles = 0;

    cmps_core_regs cmps_core_regs_i (.clock(clock), .arst_n(arst_n), .vec_valid(vec_valid),
        .vec_data(vec_data), .sreg_req(sreg_req), .reg_req(reg_req), .flag_upd(flag_upd),
        .exec_upd(exec_upd), .sat_set(sat_set), .pc_load(pc_load), .pc_target(pc_target),
        .push_req(push_req), .push_data(push_data), .pop_req(pop_req), .exc_entry(exc_entry),
        .exc_num(exc_num), .exc_return(exc_return), .svc_req(svc_req), .cps_req(cps_req),
        .cps_set(cps_set), .cps_all(cps_all), .periph_req(periph_req), .vec_rd(vec_rd),
        .vec_addr(vec_addr), .core_ready(core_ready), .sreg_rdata(sreg_rdata),
        .sreg_ack(sreg_ack), .sreg_denied(sreg_denied), .reg_rdata(reg_rdata),
        .reg_ack(reg_ack), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .handler_mode(handler_mode), .privileged(privileged), .use_psp(use_psp),
        .stack_top_pointer(stack_top_pointer), .program_counter(program_counter),
        .return_link(return_link), .svc_taken(svc_taken), .cps_denied(cps_denied),
        .periph_denied(periph_denied));

    initial begin
        forever #5 clock = ~clock;
    end

    // ----------------------------------------------------------------
    // compare, access tasks and closing report
    // ----------------------------------------------------------------
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // special move: request held one edge, answer seen one cycle later
    task sreg(input logic w, input cmps_sreg_e sel, input logic [31:0] wd,
              input logic [31:0] exp, input logic den, input string nm);
        @(posedge clock);
        sreg_req <= '{1'b1, w, sel, wd};
        @(posedge clock);
        sreg_req <= '0;
        #1;
        chk({nm, " ack"}, 1, sreg_ack);
        chk({nm, " denied"}, den, sreg_denied);
        chk({nm, " data"}, exp, sreg_rdata);
    endtask

    task rreg(input logic w, input logic [3:0] idx, input logic [31:0] wd,
              input logic [31:0] exp, input string nm);
        @(posedge clock);
        reg_req <= '{1'b1, w, idx, wd};
        @(posedge clock);
        reg_req <= '0;
        #1;
        chk({nm, " ack"}, 1, reg_ack);
        if (!w) chk(nm, exp, reg_rdata);
    endtask

    task report_and_stop;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            report_and_stop;
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clock);
        arst_n <= 1;
        @(posedge clock);
        #1;
        chk("vec_rd", 1, vec_rd);
        chk("vec_addr first", 32'h0000_0000, vec_addr);
        @(posedge clock);
        vec_valid <= 1;
        vec_data <= SP_VAL;
        @(posedge clock);
        vec_valid <= 0;
        #1;
        chk("vec_addr second", 32'h0000_0004, vec_addr);
        @(posedge clock);
        vec_valid <= 1;
        vec_data <= PC_VAL;
        @(posedge clock);
        vec_valid <= 0;
        repeat (4) if (!core_ready) @(posedge clock);
        #1;
        chk("core_ready", 1, core_ready);
        chk("main pointer", SP_VAL, stack_top_pointer);
        chk("pc boot", 32'h0000_0100, program_counter);
        chk("link reset", 32'h0FFF_FFFF, return_link);
        chk("thread mode", 0, handler_mode);
        chk("priv reset", 1, privileged);
        chk("psp sel reset", 0, use_psp);
        sreg(0, CMPS_SR_ALL, 0, 32'h0000_0000, 0, "status all reset");
        sreg(0, CMPS_SR_EXEC, 0, 32'h0000_0000, 0, "exec read");
        // condition flags and sticky saturation
        @(posedge clock);
        flag_upd <= '{1'b1, 4'hA};
        sat_set <= 1;
        @(posedge clock);
        flag_upd <= '0;
        sat_set <= 0;
        sreg(0, CMPS_SR_FLAGS, 0, 32'hA800_0000, 0, "flags");
        sreg(0, CMPS_SR_FLAGS_EXEC, 0, 32'hA800_0000, 0, "sticky sat");
        sreg(1, CMPS_SR_ALL, 32'h0600_FDFF, 0, 0, "write all");
        sreg(0, CMPS_SR_ALL, 0, 32'h0000_0000, 0, "all after write");
        // full-descending push on the main pointer
        @(posedge clock);
        push_req <= 1;
        push_data <= 32'hCAFE_0001;
        @(posedge clock);
        push_req <= 0;
        #1;
        chk("push wr", 1, mem_wr);
        chk("push addr", SP_VAL - 4, mem_addr);
        chk("push data", 32'hCAFE_0001, mem_wdata);
        chk("push ptr", SP_VAL - 4, stack_top_pointer);
        // switch to process pointer and unprivileged thread
        sreg(1, CMPS_SR_PSP, PSP_VAL, 0, 0, "psp write");
        sreg(1, CMPS_SR_CONTROL, 32'h0000_0003, 0, 0, "control write");
        chk("unpriv", 0, privileged);
        chk("psp sel", 1, use_psp);
        chk("psp active", PSP_VAL, stack_top_pointer);
        sreg(0, CMPS_SR_MSP, 0, 0, 1, "msp unpriv");
        sreg(0, CMPS_SR_EXC, 0, 0, 1, "exc unpriv");
        sreg(1, CMPS_SR_CONTROL, 0, 0, 1, "control unpriv");
        chk("still unpriv", 0, privileged);
        sreg(0, CMPS_SR_PSP, 0, PSP_VAL, 0, "psp unpriv");
        @(posedge clock);
        cps_req <= 1;
        cps_set <= 1;
        periph_req <= 1;
        svc_req <= 1;
        @(posedge clock);
        cps_req <= 0;
        periph_req <= 0;
        svc_req <= 0;
        #1;
        chk("cps denied", 1, cps_denied);
        chk("periph denied", 1, periph_denied);
        chk("svc taken", 1, svc_taken);
        // exception entry and return
        @(posedge clock);
        exc_entry <= 1;
        exc_num <= 9'd16;
        @(posedge clock);
        exc_entry <= 0;
        #1;
        chk("handler", 1, handler_mode);
        chk("handler priv", 1, privileged);
        chk("handler main", SP_VAL - 4, stack_top_pointer);
        sreg(0, CMPS_SR_EXC, 0, 32'h0000_0010, 0, "exc number");
        rreg(0, CMPS_REG_SP, 0, SP_VAL - 4, "r13 handler");
        @(posedge clock);
        exc_return <= 1;
        @(posedge clock);
        exc_return <= 0;
        #1;
        chk("thread again", 0, handler_mode);
        chk("thread unpriv", 0, privileged);
        chk("thread psp", PSP_VAL, stack_top_pointer);
        sreg(0, CMPS_SR_ALL, 0, 0, 1, "all unpriv");
        // core register port at the unprivileged level
        rreg(1, 4'h3, 32'h1234_5678, 0, "r3 write");
        rreg(0, 4'h3, 0, 32'h1234_5678, "r3 read");
        rreg(1, CMPS_REG_PC, 32'h0000_2235, 0, "pc write");
        rreg(0, CMPS_REG_PC, 0, 32'h0000_2234, "pc read");
        rreg(0, CMPS_REG_LINK, 0, 32'h0FFF_FFFF, "link read");
        report_and_stop;
    end
endmodule
